// ===== tb/tb_top.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the status group block
// ============================================================
module tb_top;
  import sgev_pkg::*;
  // apb side
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // status pins
  logic [15:0] oper_cond_in = 16'h0;
  logic [15:0] ques_cond_in = 16'h0;
  logic [15:0] dev_cond_in = 16'h0;
  logic [7:0] std_cond_in = 8'h0;
  logic msg_avail_in = 1'b0;
  logic err_queue_in = 1'b0;
  logic [4:0] group_summary;
  logic service_request;
  logic irq;
  // bookkeeping
  int failures = 0;
  int n_checks = 0;
  logic [32:0] expq [$]; // {pslverr, prdata} expected per read
  logic [31:0] seed = 32'h0000005d;

  always #10 pclk = ~pclk; // 50 mhz

  sgev_top sgev_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oper_cond_in(oper_cond_in), .ques_cond_in(ques_cond_in),
    .dev_cond_in(dev_cond_in), .std_cond_in(std_cond_in), .msg_avail_in(msg_avail_in),
    .err_queue_in(err_queue_in), .group_summary(group_summary),
    .service_request(service_request), .irq(irq));

  // xorshift source, fixed start
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // byte address of a group register
  function automatic logic [11:0] ga(input int g, input logic [2:0] r);
    return 12'(g * 32) + {7'h00, r, 2'b00};
  endfunction : ga

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // one apb transfer; the wait on pready is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      summarize();
    end
  endtask : apb

  // a read notes its expectation first, the monitor compares
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic err = 1'b0);
    expq.push_back({err, 16'h0000, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // monitor: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() > 0) begin
        chk({pslverr, prdata}, expq.pop_front());
      end else begin
        failures++;
        $display("ERROR t=%0t got=%h exp=%h", $time, prdata, 32'h0);
      end
    end
  end

  // hang guard
  initial begin
    #1000000;
    failures++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
    summarize();
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    // reset values in every group
    for (int g = 0; g < SGEV_NGRP; g++) begin
      rd(ga(g, SGEV_REG_PTR), SGEV_VALID[g]);
      rd(ga(g, SGEV_REG_NTR), SGEV_RST_NTR);
      rd(ga(g, SGEV_REG_ENA), SGEV_RST_ENA);
      rd(ga(g, SGEV_REG_EVT), 16'h0000);
    end
    rd(SGEV_OFF_IRQ_STAT, 16'h0000);
    rd(12'h200, 16'h0000, 1'b1); // unmapped word refused
    $display("test reset_values done");
    // random levels show live, bit 15 stays zero
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      oper_cond_in <= seed[15:0];
      ques_cond_in <= seed[31:16];
      idle(3);
      wr(ga(SGEV_G_OPER, SGEV_REG_COND), 32'h0);
      rd(ga(SGEV_G_OPER, SGEV_REG_COND), seed[15:0] & SGEV_VALID[0]);
      rd(ga(SGEV_G_QUES, SGEV_REG_COND), seed[31:16] & SGEV_VALID[1]);
    end
    oper_cond_in <= 16'h0;
    ques_cond_in <= 16'h0;
    idle(4);
    wr(SGEV_OFF_CTRL, 32'h1); // clear-status empties events
    rd(ga(SGEV_G_OPER, SGEV_REG_EVT), 16'h0000);
    $display("test condition done");
    // bit0 rise only, bit1 fall only, bit2 both, bit3 none
    wr(ga(SGEV_G_OPER, SGEV_REG_PTR), 32'h5);
    wr(ga(SGEV_G_OPER, SGEV_REG_NTR), 32'h6);
    wr(SGEV_OFF_CTRL, 32'h1);
    rd(ga(SGEV_G_OPER, SGEV_REG_PTR), 16'h0005);
    rd(ga(SGEV_G_OPER, SGEV_REG_NTR), 16'h0006);
    oper_cond_in <= 16'h000f;
    idle(4);
    rd(ga(SGEV_G_OPER, SGEV_REG_EVT), 16'h0005);
    rd(ga(SGEV_G_OPER, SGEV_REG_EVT), 16'h0000);
    oper_cond_in <= 16'h0000;
    idle(4);
    wr(ga(SGEV_G_OPER, SGEV_REG_EVT), 32'h0);
    rd(ga(SGEV_G_OPER, SGEV_REG_EVT), 16'h0006);
    // repeated edges while latched leave no count
    for (int i = 0; i < 2; i++) begin
      oper_cond_in <= 16'h0004;
      idle(4);
      oper_cond_in <= 16'h0000;
      idle(4);
    end
    rd(ga(SGEV_G_OPER, SGEV_REG_EVT), 16'h0004);
    rd(ga(SGEV_G_OPER, SGEV_REG_EVT), 16'h0000);
    $display("test filters done");
    // summary, read clear and the interrupt
    wr(ga(SGEV_G_OPER, SGEV_REG_ENA), 32'h1);
    wr(SGEV_OFF_IRQ_MASK, 32'h1);
    oper_cond_in <= 16'h0001;
    idle(5);
    chk(group_summary[0], 1'b1);
    chk(irq, 1'b1);
    rd(ga(SGEV_G_OPER, SGEV_REG_EVT), 16'h0001);
    #1;
    chk(group_summary[0], 1'b0);
    wr(SGEV_OFF_IRQ_MASK, 32'h0);
    #1;
    chk(irq, 1'b0); // masked
    wr(SGEV_OFF_IRQ_MASK, 32'h1);
    wr(SGEV_OFF_IRQ_STAT, 32'h1);
    #1;
    chk(irq, 1'b0); // write one clears
    oper_cond_in <= 16'h0005; // event on a disabled bit
    idle(5);
    chk(group_summary[0], 1'b0);
    rd(ga(SGEV_G_OPER, SGEV_REG_EVT), 16'h0004);
    $display("test summary done");
    // preset loads filters, enable survives preset and clear
    wr(ga(SGEV_G_QUES, SGEV_REG_ENA), 32'h1234);
    wr(SGEV_OFF_CTRL, 32'h2);
    for (int g = 0; g < SGEV_NGRP; g++) begin
      rd(ga(g, SGEV_REG_PTR), SGEV_PRESET_PTR & SGEV_VALID[g]);
      rd(ga(g, SGEV_REG_NTR), SGEV_PRESET_NTR);
    end
    wr(SGEV_OFF_CTRL, 32'h1);
    rd(ga(SGEV_G_QUES, SGEV_REG_ENA), 16'h1234);
    rd(ga(SGEV_G_QUES, SGEV_REG_ENA), 16'h1234);
    $display("test preset done");
    // standard group feeds the status byte and service request
    wr(ga(SGEV_G_STD, SGEV_REG_ENA), 32'h1);
    wr(ga(SGEV_G_STB, SGEV_REG_ENA), 32'h20);
    std_cond_in <= 8'h01;
    msg_avail_in <= 1'b1;
    idle(10);
    chk(service_request, 1'b1);
    rd(ga(SGEV_G_STB, SGEV_REG_COND), 16'h0030);
    rd(ga(SGEV_G_STD, SGEV_REG_EVT), 16'h0001);
    idle(6);
    chk(service_request, 1'b1);
    rd(ga(SGEV_G_STB, SGEV_REG_EVT), 16'h0030);
    #1;
    chk(service_request, 1'b0);
    $display("test status byte done");
    idle(2);
    if (expq.size() != 0) begin
      failures++;
    end
    summarize();
  end

endmodule : tb_top

// ===== verilog/sgev_group.sv
`timescale 1ns/1ps
// ============================================================
// one status group: transition filter, event latch, summary
// ============================================================
module sgev_group #(
  parameter logic [15:0] VALID = 16'hffff
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register file side
  sgev_grp_if.grp bus
);
  logic [15:0] prev_r;   // condition one cycle ago
  logic primed_r;        // prev_r holds a real sample
  logic [15:0] evt_r;    // sticky events
  logic [15:0] rise_w;   // qualified 0 to 1 edges
  logic [15:0] fall_w;   // qualified 1 to 0 edges
  logic [15:0] set_w;    // bits to set this cycle
  logic [15:0] evt_nxt;  // next event value

  // edges are only trusted once prev_r was loaded; a pin high at reset still shows as a rise, since the synchroniser starts at zero
  assign rise_w = bus.cond & ~prev_r & bus.ptr;
  assign fall_w = ~bus.cond & prev_r & bus.ntr;
  // both filters clear leaves the bit unable to set
  assign set_w = (rise_w | fall_w) & VALID & {16{primed_r}};
  // set wins over clear; a set bit just stays set, nothing counts
  assign evt_nxt = (evt_r & ~bus.clr & ~{16{bus.cls}}) | set_w;
  assign bus.evt = evt_r;
  // summary is combinational so a cleared event drops it at once
  assign bus.summ = |(evt_r & bus.ena);

  // condition history and event latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 16'h0000;
      primed_r <= 1'b0;
      evt_r <= 16'h0000;
    end else begin
      prev_r <= bus.cond;
      primed_r <= 1'b1;
      evt_r <= evt_nxt;
    end
  end
endmodule : sgev_group

// ===== verilog/sgev_grp_if.sv
`timescale 1ns/1ps
// ============================================================
// carrier between the register file and one status group
// ============================================================
interface sgev_grp_if;
  logic [15:0] cond;   // synchronised condition
  logic [15:0] ptr;    // rising filter
  logic [15:0] ntr;    // falling filter
  logic [15:0] ena;    // enable mask
  logic [15:0] clr;    // bits cleared by an event read
  logic cls;           // clear-status pulse
  logic [15:0] evt;    // latched events
  logic summ;          // summary bit
  modport ctl (output cond, ptr, ntr, ena, clr, cls, input evt, summ);
  modport grp (input cond, ptr, ntr, ena, clr, cls, output evt, summ);
endinterface : sgev_grp_if

// ===== verilog/sgev_pkg.sv
// ============================================================
// shared constants of the status group event summary block
// ============================================================
package sgev_pkg;

  // ==========================================================
  // group layout
  // ==========================================================
  localparam int SGEV_NGRP = 5;          // number of status groups
  localparam int SGEV_W = 16;            // storage width of every group
  localparam int SGEV_G_OPER = 0;        // operation group
  localparam int SGEV_G_QUES = 1;        // questionable group
  localparam int SGEV_G_DEV = 2;         // device group
  localparam int SGEV_G_STD = 3;         // standard event group
  localparam int SGEV_G_STB = 4;         // status byte group
  localparam int SGEV_SYNC_W = 58;       // all raw status pins, concatenated

  // implemented bits per group; upper byte of 8-bit groups and bit 15 stay zero
  localparam logic [15:0] SGEV_VALID [SGEV_NGRP] = '{
    16'h7fff, 16'h7fff, 16'h7fff, 16'h003d, 16'h00be
  };

  // status byte bit positions
  localparam int SGEV_STB_DEV = 1;
  localparam int SGEV_STB_ERR = 2;
  localparam int SGEV_STB_QUES = 3;
  localparam int SGEV_STB_MAV = 4;
  localparam int SGEV_STB_STD = 5;
  localparam int SGEV_STB_OPER = 7;

  // ==========================================================
  // register map (byte addresses, 12-bit window)
  // ==========================================================
  localparam logic [2:0] SGEV_REG_COND = 3'h0;    // +0x00 live condition, read only
  localparam logic [2:0] SGEV_REG_PTR = 3'h1;     // +0x04 rising filter
  localparam logic [2:0] SGEV_REG_NTR = 3'h2;     // +0x08 falling filter
  localparam logic [2:0] SGEV_REG_EVT = 3'h3;     // +0x0c event, read clears
  localparam logic [2:0] SGEV_REG_ENA = 3'h4;     // +0x10 enable mask
  localparam logic [11:0] SGEV_OFF_CTRL = 12'h100;     // action bits, write only
  localparam logic [11:0] SGEV_OFF_IRQ_STAT = 12'h104; // sticky, write one to clear
  localparam logic [11:0] SGEV_OFF_IRQ_MASK = 12'h108; // interrupt mask
  localparam int SGEV_CTRL_CLS = 0;       // clear-status action
  localparam int SGEV_CTRL_PRESET = 1;    // status preset action

  // ==========================================================
  // values after reset and after preset
  // ==========================================================
  localparam logic [15:0] SGEV_RST_NTR = 16'h0000;
  localparam logic [15:0] SGEV_RST_ENA = 16'h0000;
  localparam logic [15:0] SGEV_PRESET_PTR = 16'hffff;
  localparam logic [15:0] SGEV_PRESET_NTR = 16'h0000;
  localparam logic [4:0] SGEV_RST_IRQ = 5'h00;

endpackage : sgev_pkg

// ===== verilog/sgev_sync.sv
`timescale 1ns/1ps
// ============================================================
// two-stage synchroniser for raw status pins
// ============================================================
module sgev_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // first stage, read only by the second

  // plain double flop, bits are independent levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sgev_sync

// ===== verilog/sgev_top.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - condition register follows inputs, read only
// - rising edge with rising filter sets event
// - falling edge with falling filter sets event
// - both filters set: any change sets event
// - both filters clear: never sets event
// - filters read-write, kept over clear and queries
// - preset: falling filter zeros, rising filter ones
// - event sticky until read or clear-status
// - repeated events while set: no effect
// - event register read only, writes ignored
// - summary is OR of event AND enable
// - enable read-write, kept over clear and queries
// - every group has enable read and write
// - summary falls right after event read clears
// - five groups: two common, three status
// - wide groups 16 bits, bit 15 zero
module sgev_top
  import sgev_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // raw status inputs, asynchronous
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] ques_cond_in,
  input wire logic [15:0] dev_cond_in,
  input wire logic [7:0] std_cond_in,
  input wire logic msg_avail_in,
  input wire logic err_queue_in,
  // summaries and interrupt
  output logic [4:0] group_summary,
  output logic service_request,
  output logic irq
);

  // ==========================================================
  // pin synchronisation
  // ==========================================================
  logic [SGEV_SYNC_W-1:0] raw_w;   // all pins in one word
  logic [SGEV_SYNC_W-1:0] sync_w;  // same, two flops later

  assign raw_w = {err_queue_in, msg_avail_in, std_cond_in, dev_cond_in,
                  ques_cond_in, oper_cond_in};

  // one instance covers every pin; bits cross independently
  sgev_sync #(.W(SGEV_SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(raw_w),
    .q(sync_w)
  );

  // ==========================================================
  // groups
  // ==========================================================
  sgev_grp_if gi [SGEV_NGRP] ();   // one carrier per group
  logic [15:0] cond_w [SGEV_NGRP]; // condition per group
  logic [15:0] ptr_r [SGEV_NGRP];  // rising filters
  logic [15:0] ntr_r [SGEV_NGRP];  // falling filters
  logic [15:0] ena_r [SGEV_NGRP];  // enable masks
  logic [15:0] grp_rd_w [SGEV_NGRP]; // read value per group
  logic [4:0] summ_w;              // summary per group

  // conditions pass straight through, no latch on the way
  assign cond_w[SGEV_G_OPER] = sync_w[15:0] & SGEV_VALID[SGEV_G_OPER];
  assign cond_w[SGEV_G_QUES] = sync_w[31:16] & SGEV_VALID[SGEV_G_QUES];
  assign cond_w[SGEV_G_DEV] = sync_w[47:32] & SGEV_VALID[SGEV_G_DEV];
  assign cond_w[SGEV_G_STD] = {8'h00, sync_w[55:48]} & SGEV_VALID[SGEV_G_STD];

  // status byte sits on top of the others; no loop since it reads their summaries and two pins, never its own
  always_comb begin
    cond_w[SGEV_G_STB] = 16'h0000;
    cond_w[SGEV_G_STB][SGEV_STB_DEV] = summ_w[SGEV_G_DEV];
    cond_w[SGEV_G_STB][SGEV_STB_ERR] = sync_w[57];
    cond_w[SGEV_G_STB][SGEV_STB_QUES] = summ_w[SGEV_G_QUES];
    cond_w[SGEV_G_STB][SGEV_STB_MAV] = sync_w[56];
    cond_w[SGEV_G_STB][SGEV_STB_STD] = summ_w[SGEV_G_STD];
    cond_w[SGEV_G_STB][SGEV_STB_OPER] = summ_w[SGEV_G_OPER];
  end

  // ==========================================================
  // apb decode
  // ==========================================================
  logic setup_w;     // first cycle of a transfer
  logic access_w;    // completing cycle, pready is always high
  logic wr_w;        // write takes effect now
  logic rd_w;        // read completes now
  logic [2:0] gidx_w; // addressed group
  logic [2:0] ridx_w; // addressed register inside the group
  logic hit_grp_w;   // group register addressed
  logic hit_ctrl_w;  // action register
  logic hit_stat_w;  // interrupt status
  logic hit_mask_w;  // interrupt mask
  logic hit_w;       // any mapped word
  logic preset_w;    // preset action this cycle
  logic cls_w;       // clear-status action this cycle
  logic [31:0] rdata_w; // selected read word
  logic [31:0] prdata_r; // captured read word

  assign setup_w = psel & ~penable;
  assign access_w = psel & penable;
  assign wr_w = access_w & pwrite;
  assign rd_w = access_w & ~pwrite;
  assign gidx_w = paddr[7:5];
  assign ridx_w = paddr[4:2];
  assign hit_grp_w = (paddr[11:8] == 4'h0) & (gidx_w < 3'(SGEV_NGRP)) &
                     (ridx_w <= SGEV_REG_ENA) & (paddr[1:0] == 2'h0);
  assign hit_ctrl_w = (paddr == SGEV_OFF_CTRL);
  assign hit_stat_w = (paddr == SGEV_OFF_IRQ_STAT);
  assign hit_mask_w = (paddr == SGEV_OFF_IRQ_MASK);
  assign hit_w = hit_grp_w | hit_ctrl_w | hit_stat_w | hit_mask_w;
  // filters are only touched by writes and preset, never by queries or clear
  assign preset_w = wr_w & hit_ctrl_w & pwdata[SGEV_CTRL_PRESET];
  assign cls_w = wr_w & hit_ctrl_w & pwdata[SGEV_CTRL_CLS];

  // zero wait states; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = access_w & ~hit_w;
  assign prdata = prdata_r;

  // ==========================================================
  // per-group registers
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < SGEV_NGRP; g++) begin : gen_grp
      logic sel_w;     // this group addressed
      logic wr_ptr_w;  // rising filter write
      logic wr_ntr_w;  // falling filter write
      logic wr_ena_w;  // enable write

      assign sel_w = hit_grp_w & (gidx_w == 3'(g));
      assign wr_ptr_w = wr_w & sel_w & (ridx_w == SGEV_REG_PTR);
      assign wr_ntr_w = wr_w & sel_w & (ridx_w == SGEV_REG_NTR);
      assign wr_ena_w = wr_w & sel_w & (ridx_w == SGEV_REG_ENA);

      // read mux; a write to the event word has no path, so it is ignored
      assign grp_rd_w[g] = (ridx_w == SGEV_REG_COND) ? cond_w[g] :
                           (ridx_w == SGEV_REG_PTR) ? ptr_r[g] :
                           (ridx_w == SGEV_REG_NTR) ? ntr_r[g] :
                           (ridx_w == SGEV_REG_EVT) ? gi[g].evt : ena_r[g];

      // filters: reset to the preset state
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ptr_r[g] <= SGEV_PRESET_PTR & SGEV_VALID[g];
          ntr_r[g] <= SGEV_RST_NTR;
        end else if (preset_w) begin
          ptr_r[g] <= SGEV_PRESET_PTR & SGEV_VALID[g];
          ntr_r[g] <= SGEV_PRESET_NTR;
        end else begin
          if (wr_ptr_w) begin
            ptr_r[g] <= pwdata[15:0] & SGEV_VALID[g];
          end
          if (wr_ntr_w) begin
            ntr_r[g] <= pwdata[15:0] & SGEV_VALID[g];
          end
        end
      end

      // enable mask, untouched by clear-status and preset
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ena_r[g] <= SGEV_RST_ENA;
        end else if (wr_ena_w) begin
          ena_r[g] <= pwdata[15:0] & SGEV_VALID[g];
        end
      end

      // carrier wiring; the read clears exactly the word captured at setup
      assign gi[g].cond = cond_w[g];
      assign gi[g].ptr = ptr_r[g];
      assign gi[g].ntr = ntr_r[g];
      assign gi[g].ena = ena_r[g];
      assign gi[g].clr = (rd_w & sel_w & (ridx_w == SGEV_REG_EVT)) ?
                         prdata_r[15:0] : 16'h0000;
      assign gi[g].cls = cls_w;
      assign summ_w[g] = gi[g].summ;

      sgev_group #(.VALID(SGEV_VALID[g])) u_grp (
        .pclk(pclk),
        .presetn(presetn),
        .bus(gi[g])
      );
    end
  endgenerate

  // ==========================================================
  // read path
  // ==========================================================
  logic [4:0] irq_stat_r; // sticky summary rises
  logic [4:0] irq_mask_r; // interrupt mask
  logic [4:0] summ_prev_r; // summaries one cycle ago
  logic [4:0] irq_set_w;  // rises this cycle
  logic [4:0] irq_clr_w;  // write-one-to-clear bits

  // control word reads zero; its bits are actions, not state
  assign rdata_w = hit_grp_w ? {16'h0000, grp_rd_w[gidx_w]} :
                   hit_stat_w ? {27'h0000000, irq_stat_r} :
                   hit_mask_w ? {27'h0000000, irq_mask_r} : 32'h00000000;

  // captured in setup so the value read is the value cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup_w & ~pwrite) begin
      prdata_r <= rdata_w;
    end
  end

  // ==========================================================
  // interrupt
  // ==========================================================
  assign irq_set_w = summ_w & ~summ_prev_r;
  assign irq_clr_w = (wr_w & hit_stat_w) ? pwdata[4:0] : 5'h00;

  // sticky status, a rise in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= SGEV_RST_IRQ;
      summ_prev_r <= 5'h00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr_w) | irq_set_w;
      summ_prev_r <= summ_w;
    end
  end

  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= SGEV_RST_IRQ;
    end else if (wr_w & hit_mask_w) begin
      irq_mask_r <= pwdata[4:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);
  assign group_summary = summ_w;
  assign service_request = summ_w[SGEV_G_STB];

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic run_r; // history valid, mirrors the groups' primed flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
    end
  end

  logic [15:0] keep0_w; // bits of group 0 that must survive
  assign keep0_w = gi[0].evt & ~gi[0].clr & ~{16{gi[0].cls}};

  a_cond_readback: assert property (setup_w && !pwrite && hit_grp_w && gidx_w == 3'h0 &&
    ridx_w == SGEV_REG_COND |=> prdata[15:0] == $past(cond_w[0]))
    else $error("condition readback differs from live condition");
  a_rise_sets: assert property (run_r && $rose(cond_w[0][0]) && ptr_r[0][0]
    |=> gi[0].evt[0])
    else $error("rising edge with rising filter did not set event");
  a_fall_sets: assert property (run_r && $fell(cond_w[0][3]) && ntr_r[0][3]
    |=> gi[0].evt[3])
    else $error("falling edge with falling filter did not set event");
  a_both_any: assert property (run_r && (cond_w[1][8] != $past(cond_w[1][8])) &&
    ptr_r[1][8] && ntr_r[1][8] |=> gi[1].evt[8])
    else $error("change with both filters did not set event");
  a_none_never: assert property (!ptr_r[2][5] && !ntr_r[2][5] && !gi[2].evt[5]
    |=> !gi[2].evt[5])
    else $error("event set with both filters clear");
  a_filter_keep: assert property ((cls_w && !preset_w) || rd_w |=>
    $stable(ptr_r[0]) && $stable(ntr_r[0]))
    else $error("filter changed by clear or query");
  a_preset_load: assert property (preset_w |=> ptr_r[3] == SGEV_VALID[3] &&
    ntr_r[3] == 16'h0000 ##1 $stable(ptr_r[3]) || $past(wr_w))
    else $error("preset did not load filters");
  a_evt_hold: assert property (1'b1 |=> (gi[0].evt & $past(keep0_w)) == $past(keep0_w))
    else $error("event bit lost without read or clear");
  a_evt_readonly: assert property (wr_w && hit_grp_w && gidx_w == 3'h0 &&
    ridx_w == SGEV_REG_EVT |=> ($past(gi[0].evt) & ~gi[0].evt) == 16'h0000)
    else $error("write altered event register");
  a_ena_keep: assert property (cls_w || preset_w |=> $stable(ena_r[4]))
    else $error("enable changed by clear or preset");
  a_clear_drops: assert property (gi[0].clr == gi[0].evt && gi[0].clr != 16'h0000 &&
    $stable(cond_w[0]) |=> !summ_w[0])
    else $error("summary stayed high after read clear");
  a_bit15_zero: assert property ((gi[2].evt & ~SGEV_VALID[2]) == 16'h0000 &&
    (gi[3].evt & ~SGEV_VALID[3]) == 16'h0000)
    else $error("unimplemented event bit set");
  a_clear_subset: assert property ((gi[1].clr & ~gi[1].evt) == 16'h0000)
    else $error("read clear covers bits not latched");

  c_rise_event: cover property (run_r && $rose(cond_w[0][0]) ##1 gi[0].evt[0]);
  c_read_clear: cover property (gi[1].clr != 16'h0000 ##1 !summ_w[1]);
  c_preset: cover property (preset_w ##1 ptr_r[0] == SGEV_VALID[0]);
  c_irq: cover property (!irq ##1 irq);

endmodule : sgev_top
